/* hw/reset_status_pkg.sv */
// Package of constants and types for the reset-source status and debug reset block.
package reset_status_pkg;

   // ****************************************
   // Status and force register field positions
   // ****************************************
   localparam int PowerOnBit      = 7;
   localparam int ExtPinBit       = 6;
   localparam int WatchdogBit     = 5;
   localparam int IllegalOpBit    = 4;
   localparam int IllegalAddrBit  = 3;
   localparam int LowVoltageBit   = 1;
   localparam int ForceResetBit   = 0;

   // ****************************************
   // Values
   // ****************************************
   localparam logic [7:0] StatusPorValue = 8'h82;
   localparam logic [7:0] StatusLvrValue = 8'h02;
   localparam logic [7:0] StatusClear    = 8'h00;
   localparam logic [7:0] ForceReadValue = 8'h00;
   localparam logic [7:0] StatusLiveMask = 8'hfa;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      SelNone,
      SelStatus,
      SelForce
   } regSel_t;

   // Reset causes sampled at reset entry.
   typedef struct packed {
      logic powerOn;
      logic lowVoltage;
      logic extPin;
      logic watchdog;
      logic illegalOp;
      logic illegalAddr;
   } resetCause_t;

   // Register access from the CPU or the debug link.
   typedef struct packed {
      regSel_t    sel;
      logic       wr;
      logic       rd;
      logic       fromDebug;
      logic [7:0] wdata;
   } regAccess_t;

endpackage

/* hw/reset_cause_status.sv */
// Reset-source status register and debug-forced reset control.
`timescale 1ns/1ps

module reset_cause_status
   import reset_status_pkg::*;
(
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Reset causes present at reset entry and the options that qualify them
   input  wire reset_status_pkg::resetCause_t cause,
   input  wire logic                         lowVoltageResetEnable,
   input  wire logic                         watchdogEnableOption,
   input  wire logic                         stopAllowOption,
   input  wire logic                         backgroundModeAllow,
   input  wire logic                         stopExecuted,
   input  wire logic                         backgroundExecuted,
   // Register access
   input  wire reset_status_pkg::regAccess_t acc,
   output logic [7:0]                        rdata,
   // Control outputs
   output logic                              watchdogRestart,
   output logic                              forceReset
);
   import reset_status_pkg::*;

   // ****************************************
   // Access decoding
   // ****************************************

   // True when the access is a write aimed at the given register.
   function automatic logic writeTo(
      input regAccess_t a,
      input regSel_t    s
   );
      return a.wr && (a.sel == s);
   endfunction

   // True when the access is a read aimed at the given register.
   function automatic logic readFrom(
      input regAccess_t a,
      input regSel_t    s
   );
      return a.rd && (a.sel == s);
   endfunction

   // ****************************************
   // Cause decoding
   // ****************************************

   // Flag pattern for a reset that is neither power-on nor low-voltage.
   function automatic logic [7:0] sourceFlags(
      input logic extPin,
      input logic watchdog,
      input logic illegalOpcode,
      input logic illegalAddress
   );
      logic [7:0] flags;
      flags                 = StatusClear;
      flags[ExtPinBit]      = extPin;
      flags[WatchdogBit]    = watchdog;
      flags[IllegalOpBit]   = illegalOpcode;
      flags[IllegalAddrBit] = illegalAddress;
      return flags & StatusLiveMask;
   endfunction

   // Picks what the reset being entered leaves behind. A debug-forced reset
   // wins over every other cause, then power-on, then an enabled low-voltage trip.
   function automatic logic [7:0] entryFlags(
      input logic       forced,
      input logic       powerOn,
      input logic       lowVoltage,
      input logic [7:0] others
   );
      logic [7:0] flags;
      if (forced) begin
         flags = StatusClear;
      end else if (powerOn) begin
         flags = StatusPorValue;
      end else if (lowVoltage) begin
         flags = StatusLvrValue;
      end else begin
         flags = others;
      end
      return flags & StatusLiveMask;
   endfunction

   // ****************************************
   // Cause qualification
   // ****************************************

   logic       illegalOp;
   logic       wdogCause;
   logic       lvCause;
   logic [7:0] otherFlags;

   // Stop and background instructions only count as illegal while not allowed.
   assign illegalOp = cause.illegalOp
                      | (stopExecuted & ~stopAllowOption)
                      | (backgroundExecuted & ~backgroundModeAllow);

   // A disabled watchdog can never be named as the source of a reset.
   assign wdogCause = cause.watchdog & watchdogEnableOption;

   // A supply dip only counts while the low-voltage reset is enabled.
   assign lvCause = cause.lowVoltage & lowVoltageResetEnable;

   assign otherFlags = sourceFlags(cause.extPin,
                                   wdogCause,
                                   illegalOp,
                                   cause.illegalAddr);

   // ****************************************
   // Forced-reset memory
   // ****************************************

   logic forceReq;
   logic forceSeen_q;
   logic forceSeen_d;

   // Only the debug link may force a reset, and only with the control bit set.
   assign forceReq = writeTo(acc, SelForce)
                     & acc.fromDebug
                     & acc.wdata[ForceResetBit];

   // The request is kept through the system reset that it triggers, so that the
   // flags are cleared whatever the other causes show; it lapses at release.
   // Reset must already be high at the edge that ends the force pulse.
   // Power-on drops it, since the memory holds no defined value before then.
   always_comb begin
      forceSeen_d = forceReq;
      if (rst) begin
         forceSeen_d = forceSeen_q & ~cause.powerOn;
      end
   end

   always_ff @(posedge clk) begin
      forceSeen_q <= forceSeen_d;
   end

   // ****************************************
   // Status flags
   // ****************************************

   logic [7:0] status_q;
   logic [7:0] status_d;

   // The flags have no reset value of their own: they are loaded on every edge
   // while reset is held, so the last edge of reset decides what software sees.
   // Outside reset nothing, writes included, alters them.
   always_comb begin
      status_d = status_q;
      if (rst) begin
         status_d = entryFlags(forceSeen_q, cause.powerOn, lvCause, otherFlags);
      end
   end

   always_ff @(posedge clk) begin
      status_q <= status_d;
   end

   // ****************************************
   // Read data
   // ****************************************

   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   // Unmapped reads and reads during reset return zero.
   always_comb begin
      rdata_d = 8'h00;
      if (!rst) begin
         if (readFrom(acc, SelStatus)) begin
            rdata_d = status_q & StatusLiveMask;
         end else if (readFrom(acc, SelForce)) begin
            rdata_d = ForceReadValue;
         end
      end
   end

   always_ff @(posedge clk) begin
      rdata_q <= rdata_d;
   end

   // ****************************************
   // Control pulses
   // ****************************************

   logic restart_q;
   logic restart_d;
   logic force_q;
   logic force_d;

   // Each pulse lasts one cycle per accepted write; nothing is taken during reset.
   always_comb begin
      restart_d = 1'b0;
      force_d   = 1'b0;
      if (!rst) begin
         restart_d = writeTo(acc, SelStatus);
         force_d   = forceReq;
      end
   end

   always_ff @(posedge clk) begin
      restart_q <= restart_d;
      force_q   <= force_d;
   end

   // ****************************************
   // Outputs
   // ****************************************

   assign rdata           = rdata_q;
   assign watchdogRestart = restart_q;
   assign forceReset      = force_q;

endmodule

/* verif/reset_cause_status_properties.sv */
// Port checks for the reset status block.
`timescale 1ns/1ps
module reset_cause_status_chk
   import reset_status_pkg::*;
(
   input wire logic                         clk,
   input wire logic                         rst,
   input wire reset_status_pkg::regAccess_t acc,
   input wire logic [7:0]                   rdata,
   input wire logic                         watchdogRestart,
   input wire logic                         forceReset
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire stW = acc.wr && acc.sel == SelStatus;
   wire stR = acc.rd && acc.sel == SelStatus;
   wire fW = acc.wr && acc.sel == SelForce;
   sequence s_rd2; stR ##1 stR; endsequence
   property p_wdr; stW |=> watchdogRestart; endproperty
   a_wdr: assert property (p_wdr) else $error("no restart");
   property p_nowdr; !stW |=> !watchdogRestart; endproperty
   a_nowdr: assert property (p_nowdr) else $error("stray restart");
   property p_frc; fW && acc.fromDebug && acc.wdata[0] |=> forceReset; endproperty
   a_frc: assert property (p_frc) else $error("no force");
   property p_usr; fW && !acc.fromDebug |=> !forceReset; endproperty
   a_usr: assert property (p_usr) else $error("user force");
   property p_one; !(fW && acc.fromDebug && acc.wdata[0]) |=> !forceReset; endproperty
   a_one: assert property (p_one) else $error("stray force");
   property p_frd; acc.rd && acc.sel == SelForce |=> rdata == 8'h00; endproperty
   a_frd: assert property (p_frd) else $error("force read");
   property p_pad; acc.rd |=> !rdata[2] && !rdata[0]; endproperty
   a_pad: assert property (p_pad) else $error("pad bits");
   property p_hold; s_rd2 |=> rdata == $past(rdata); endproperty
   a_hold: assert property (p_hold) else $error("status moved");
endmodule
bind reset_cause_status reset_cause_status_chk i_chk(.clk, .rst, .acc, .rdata,
   .watchdogRestart, .forceReset);

/* verif/debug_host_model.sv */
// Debug host that forces one reset over the debug link.
`timescale 1ns/1ps
module debug_host_model
   import reset_status_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     go,
   output reset_status_pkg::regAccess_t hostAcc,
   output logic                         debugPin
);
   initial begin
      hostAcc  = '0;
      debugPin = 1'b1;
      @(posedge go);
      @(negedge clk);
      // The wire is busy while the command is sent.
      hostAcc  = '{SelForce, 1'b1, 1'b0, 1'b1, 8'h01};
      debugPin = 1'b0;
      @(negedge clk);
      // High right after the command selects user mode on the coming reset.
      hostAcc  = '0;
      debugPin = 1'b1;
   end
endmodule

/* verif/reset_cause_status_tb_top.sv */
// Testbench for the reset status block.
`timescale 1ns/1ps
module reset_cause_status_tb_top;
   import reset_status_pkg::*;
   logic clk = 0, rst = 1, go = 0, wdr, frc, pin;
   resetCause_t cause = '0;
   logic [5:0] opt = '0;
   regAccess_t accTb = '0, hostAcc;
   logic [7:0] rdata;
   int mismatches = 0, total_checks = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   debug_host_model i_host(.clk, .go, .hostAcc, .debugPin(pin));
   reset_cause_status i_dut(.clk, .rst, .cause, .lowVoltageResetEnable(opt[5]),
      .watchdogEnableOption(opt[4]), .stopAllowOption(opt[3]),
      .backgroundModeAllow(opt[2]), .stopExecuted(opt[1]), .backgroundExecuted(opt[0]),
      .acc(accTb | hostAcc), .rdata, .watchdogRestart(wdr), .forceReset(frc));
   task give_verdict;
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Every access is taken twice back to back; a read checks what it returned.
   task op(input regSel_t s, input logic w, input logic [7:0] d, e);
      @(negedge clk);
      accTb = '{s, w, !w, 1'b0, d};
      repeat (2) @(negedge clk);
      accTb = '0;
      if (!w) chk("rdata", e, rdata);
   endtask
   task rs(input resetCause_t c, input logic [5:0] o, input logic [7:0] e);
      @(negedge clk);
      rst = 1;
      cause = c;
      opt = o;
      repeat (4) @(negedge clk);
      rst = 0;
      op(SelStatus, 0, 0, e);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         mismatches++;
         give_verdict;
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rs(6'h20, 6'h00, 8'h82);
      rs(6'h10, 6'h20, 8'h02);
      rs(6'h18, 6'h00, 8'h40);
      rs(6'h0f, 6'h10, 8'h78);
      rs(6'h04, 6'h00, 8'h00);
      rs(6'h00, 6'h0f, 8'h00);
      rs(6'h00, 6'h02, 8'h10);
      rs(6'h00, 6'h01, 8'h10);
      op(SelStatus, 1, 8'hff, 0);
      chk("restart", 8'h01, {7'h0, wdr});
      op(SelStatus, 0, 0, 8'h10);
      op(SelForce, 1, 8'h01, 0);
      chk("force", 8'h00, {7'h0, frc});
      op(SelForce, 0, 0, 8'h00);
      @(negedge clk);
      go = 1;
      repeat (2) @(negedge clk);
      chk("force", 8'h01, {7'h0, frc});
      // The system answers the force pulse with a reset at the very next edge.
      rst = 1;
      @(posedge clk);
      chk("debug pin", 8'h01, {7'h0, pin});
      rs(6'h08, 6'h00, 8'h00);
      give_verdict;
   end
endmodule
